/* File: verilog/dps_pkg.sv */
// package for the dual-port semaphore port controller (host side)
// assumes one 200 MHz clock domain and an asynchronous sram-style port
package dps_pkg;
   localparam int ADDR_W      = 17;
   localparam int DATA_W      = 9;
   localparam int IDX_W       = 3;
   localparam int SEM_COUNT   = 8;
   localparam int CLK_PERIOD_NS = 5;
   // least time each sequencer phase lasts, in ns; write strobes drop one cycle early
   localparam int PHASE_NS    = 20;
   localparam int PHASE_CYC   = (PHASE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int CNT_W       = 4;
   localparam logic [0:0] FLAG_TAKEN = 1'h0;
   localparam logic [0:0] FLAG_FREE  = 1'h1;

   typedef enum logic [1:0] {
      DPS_OP_ACQUIRE = 2'h0,   // write zero, then read back
      DPS_OP_RELEASE = 2'h1,   // write one
      DPS_OP_POLL    = 2'h2    // plain read
   } dps_op_t;

   typedef struct packed {
      dps_op_t          op;
      logic [IDX_W-1:0] index;
   } dps_cmd_t;

   // pins driven toward the ram port
   typedef struct packed {
      logic              semaphore_select_n;
      logic              ce_n;
      logic              rw_n;
      logic              oe_n;
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] dout;
      logic              dout_en;
   } dps_pins_t;
endpackage : dps_pkg

/* File: verilog/dps_host.sv */
// host controller driving the semaphore space of one dual-port ram port
// assumes the ram pins are asynchronous; data in is synchronised here
// assumes the far port frees its own request latches after power-up
// clk_en low freezes every flop, pins included, even mid-access
// Summary of operation
// - request by writing zero, release by writing one, same port
// - select semaphores with select low, ce held high; r/w, address as ram
// - polling must drop select or output enable between reads
// - acquire writes zero first, then reads back
// - failed request is followed by rereads or a release
// - software frees all eight flags from both ports at start; here the power-up sweep releases all eight from this side only
module dps_host
   import dps_pkg::*;
(
   // clock and reset
   input  wire logic              clk,
   input  wire logic              rst_b,
   input  wire logic              clk_en,
   // command port
   input  wire logic              cmd_valid,
   input  wire dps_cmd_t          cmd,
   output logic                   cmd_ready_q,
   output logic                   done_q,
   output logic                   owned_q,
   output logic [DATA_W-1:0]      rdata_q,
   // ram port pins
   output logic                   semaphore_select_n_q,
   output logic                   ce_n_q,
   output logic                   rw_n_q,
   output logic                   oe_n_q,
   output logic [ADDR_W-1:0]      addr_q,
   output logic [DATA_W-1:0]      dout_q,
   output logic                   dout_en_q,
   input  wire logic [DATA_W-1:0] din
);
   typedef enum logic [2:0] {
      DPS_IDLE, DPS_WRITE, DPS_GAP, DPS_READ, DPS_SAMPLE, DPS_DONE
   } dps_state_t;

   dps_state_t       state_q;
   dps_cmd_t         cmd_q;
   logic [CNT_W-1:0] cnt_q;
   logic [DATA_W-1:0] din_meta_q;
   logic [DATA_W-1:0] din_sync_q;
   logic             phase_end;
   // power-up sweep state
   logic             init_q;
   logic [IDX_W-1:0] init_idx_q;

   assign phase_end = (cnt_q == CNT_W'(PHASE_CYC - 1));

   // two-flop synchroniser on the asynchronous data pins
   // only din_sync_q is read by logic; din_meta_q may be metastable
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         din_meta_q <= '0;
         din_sync_q <= '0;
      end else if (clk_en) begin
         din_meta_q <= din;
         din_sync_q <= din_meta_q;
      end
   end

   // phase timer
   // the last cycle of a write phase drops the strobes and dout_en_q together,
   // so the data is not driven once the write ends
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         cnt_q <= '0;
      end else if (clk_en) begin
         if (state_q == DPS_IDLE || state_q == DPS_DONE || phase_end) begin
            cnt_q <= '0;
         end else begin
            cnt_q <= cnt_q + CNT_W'(1);
         end
      end
   end

   // power-up sweep: the flags come up in no known state, so each one is
   // released from this side before any command is taken
   // the far port must free its own request latches as well; this side
   // cannot reach them
   // a reset in mid-run restarts the sweep, since a write may have been cut
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         init_q     <= 1'h1;
         init_idx_q <= '0;
      end else if (clk_en) begin
         if (init_q && state_q == DPS_WRITE && phase_end) begin
            init_idx_q <= init_idx_q + IDX_W'(1);
            if (init_idx_q == IDX_W'(SEM_COUNT - 1)) begin
               init_q <= 1'h0;
            end
         end
      end
   end

   // sequencer
   // release has no read-back, so it ends straight after its write
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         state_q <= DPS_IDLE;
         cmd_q   <= '0;
      end else if (clk_en) begin
         case (state_q)
            DPS_IDLE: begin
               if (init_q) begin
                  cmd_q   <= '{op: DPS_OP_RELEASE, index: init_idx_q};
                  state_q <= DPS_WRITE;
               end else if (cmd_valid) begin
                  cmd_q <= cmd;
                  // acquire always writes before reading
                  state_q <= (cmd.op == DPS_OP_POLL) ? DPS_READ : DPS_WRITE;
               end
            end
            DPS_WRITE: begin
               if (phase_end) begin
                  state_q <= (cmd_q.op == DPS_OP_ACQUIRE) ? DPS_GAP : DPS_DONE;
               end
            end
            DPS_GAP: begin
               if (phase_end) begin
                  state_q <= DPS_READ;
               end
            end
            DPS_READ: begin
               if (phase_end) begin
                  state_q <= DPS_SAMPLE;
               end
            end
            DPS_SAMPLE: begin
               if (phase_end) begin
                  state_q <= DPS_DONE;
               end
            end
            default: begin
               state_q <= DPS_IDLE;
            end
         endcase
      end
   end

   // pins: every access ends with select high, so the next read recaptures
   // and the idle port rests in standby
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         semaphore_select_n_q <= 1'h1;
         ce_n_q               <= 1'h1;
         rw_n_q               <= 1'h1;
         oe_n_q               <= 1'h1;
         addr_q               <= '0;
         dout_q               <= '0;
         dout_en_q            <= 1'h0;
      end else if (clk_en) begin
         ce_n_q  <= 1'h1;
         rw_n_q  <= 1'h1;
         oe_n_q  <= 1'h1;
         dout_en_q <= 1'h0;
         semaphore_select_n_q <= 1'h1;
         // only the index bits carry meaning; upper address held zero
         addr_q  <= {{(ADDR_W-IDX_W){1'h0}}, cmd_q.index};
         if (state_q == DPS_WRITE && !phase_end) begin
            semaphore_select_n_q <= 1'h0;
            rw_n_q    <= 1'h0;
            dout_en_q <= 1'h1;
            // release writes one, acquire writes zero on bit 0
            dout_q <= {{(DATA_W-1){1'h0}},
                       (cmd_q.op == DPS_OP_RELEASE) ? FLAG_FREE
                                                    : FLAG_TAKEN};
         // select and output enable fall together so the flag is captured
         // once per read; both rise again before the next access
         end else if ((state_q == DPS_READ) ||
                      (state_q == DPS_SAMPLE && !phase_end)) begin
            semaphore_select_n_q <= 1'h0;
            oe_n_q <= 1'h0;
         end
      end
   end

   // results: flag is replicated, so bit 0 alone decides ownership
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         rdata_q     <= '0;
         owned_q     <= 1'h0;
         done_q      <= 1'h0;
         cmd_ready_q <= 1'h0;
      end else if (clk_en) begin
         done_q      <= (state_q == DPS_SAMPLE) && phase_end;
         // commands wait until the power-up sweep is over
         cmd_ready_q <= (state_q == DPS_IDLE) && !cmd_valid &&
                        !init_q;
         // rdata_q is taken several cycles after the read began, well past
         // the two-flop synchroniser delay
         if (state_q == DPS_SAMPLE && phase_end) begin
            rdata_q <= din_sync_q;
            // a one here means the request is only pending
            // owned low after acquire: software rereads or releases
            // so its request does not stay latched
            owned_q <= (din_sync_q[0] == FLAG_TAKEN);
         end else if (state_q == DPS_WRITE && phase_end &&
                      cmd_q.op == DPS_OP_RELEASE) begin
            owned_q <= 1'h0;
         end
      end
   end
endmodule : dps_host

/* File: verification/dps_host_props.sv */
// checker on the pins of the semaphore host controller
// assumes it is bound into every dps_host instance
module dps_host_props
   import dps_pkg::*;
(
   // clock, reset and status
   input wire logic              clk, rst_b, done_q, owned_q, cmd_ready_q,
   // ram port pins and read data
   input wire logic              semaphore_select_n_q, ce_n_q, rw_n_q,
   input wire logic              oe_n_q, dout_en_q,
   input wire logic [DATA_W-1:0] rdata_q, dout_q,
   input wire logic [ADDR_W-1:0] addr_q
);
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_b);
   sequence s_wr; !semaphore_select_n_q && !rw_n_q; endsequence
   sequence s_rd; !semaphore_select_n_q && !oe_n_q; endsequence
   property p_addr; !semaphore_select_n_q |-> addr_q[ADDR_W-1:IDX_W] == '0;
   endproperty
   property p_wr; s_wr |-> dout_en_q && oe_n_q && ce_n_q; endproperty
   property p_rd; s_rd |-> !dout_en_q && rw_n_q; endproperty
   property p_stby; cmd_ready_q |-> semaphore_select_n_q && ce_n_q;
   endproperty
   property p_hold; s_wr ##1 s_wr |-> $stable(addr_q) && $stable(dout_q);
   endproperty
   // a request is always confirmed by a read-back
   property p_wrrd; $rose(rw_n_q) && !$past(dout_q[0]) |-> ##[1:12] s_rd;
   endproperty
   property p_rel; $rose(rw_n_q) && $past(dout_q[0]) |-> oe_n_q [*2];
   endproperty
   property p_poll; $fell(oe_n_q) |-> ##[1:12] oe_n_q; endproperty
   property p_own; done_q |-> rdata_q inside {'0, '1} &&
      owned_q == (rdata_q[0] == FLAG_TAKEN) ##1 !done_q; endproperty
   a_addr: assert property (p_addr) else $error("high address bits set");
   a_wr: assert property (p_wr) else $error("bad write strobes");
   a_rd: assert property (p_rd) else $error("bad read strobes");
   a_stby: assert property (p_stby) else $error("idle not standby");
   a_hold: assert property (p_hold) else $error("write unstable");
   a_wrrd: assert property (p_wrrd) else $error("no read-back");
   a_rel: assert property (p_rel) else $error("read after release");
   a_poll: assert property (p_poll) else $error("read never ends");
   a_own: assert property (p_own) else $error("owned mismatch");
endmodule : dps_host_props
bind dps_host dps_host_props u_props (.*);

/* File: verification/dps_sem_model.sv */
// behavioural semaphore space of the ram as seen from the host port
// the far port is worked by the bench through the oth_ strobes
module dps_sem_model
   import dps_pkg::*;
(
   // host port
   input  wire logic              sel_n, rw_n, oe_n,
   input  wire logic [ADDR_W-1:0] addr,
   input  wire logic [DATA_W-1:0] dout,
   output logic      [DATA_W-1:0] din,
   // far port
   input  wire logic              oth_we, oth_val,
   input  wire logic [IDX_W-1:0]  oth_idx
);
   // not initialised: every flag starts owned, so software must free it
   logic [SEM_COUNT-1:0] rq_l = '0, rq_r = '0, ow_l = '1, ow_r = '0;
   logic                 cap = 1'b0;
   wire wr = !(sel_n | rw_n);
   wire rd = !(sel_n | oe_n); // flags gate nothing else
   task automatic settle(input int i);
      if (!ow_l[i] && !ow_r[i])
         {ow_l[i], ow_r[i]} = {!rq_l[i], rq_l[i] && !rq_r[i]};
      if (ow_l[i] && rq_l[i]) {ow_l[i], ow_r[i]} = {1'b0, !rq_r[i]};
      if (ow_r[i] && rq_r[i]) {ow_r[i], ow_l[i]} = {1'b0, !rq_l[i]};
   endtask : settle
   always @(posedge wr) begin
      #1 rq_l[addr[IDX_W-1:0]] = dout[0];
      settle(addr[IDX_W-1:0]);
   end
   always @(posedge oth_we) begin
      rq_r[oth_idx] = oth_val;
      settle(oth_idx);
   end
   always @(posedge rd) #1 cap = !ow_l[addr[IDX_W-1:0]];
   // a released bus shows the inverse so a stale value cannot pass
   assign din = rd ? {DATA_W{cap}} : {DATA_W{~cap}};
endmodule : dps_sem_model

/* File: verification/dps_host_tb.sv */
// self-checking bench for dps_host against the semaphore model
// assumes one 200 MHz clock; inputs move on the falling edge
module dps_host_tb
   import dps_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   typedef struct packed {logic [1:0] oth; dps_op_t op;
      logic [2:0] idx; logic own;} dps_row_t;
   localparam dps_row_t ROWS [8] = '{'{0, DPS_OP_ACQUIRE, 3, 1},
      '{1, DPS_OP_POLL, 3, 1}, '{0, DPS_OP_RELEASE, 3, 0},
      '{0, DPS_OP_POLL, 3, 0}, '{0, DPS_OP_ACQUIRE, 3, 0},
      '{2, DPS_OP_POLL, 3, 1}, '{0, DPS_OP_RELEASE, 3, 0},
      '{0, DPS_OP_POLL, 3, 0}};
   logic clk = 0, rst_b = 0, cmd_valid = 0, oth_we = 0, oth_val = 0;
   logic clk_en = 1;
   logic [3:0] pins;
   logic [IDX_W-1:0] oth_idx = '0;
   dps_cmd_t cmd = '0;
   logic rdy, done_q, owned_q, sel_n, rw_n, oe_n, den;
   logic [DATA_W-1:0] rdata_q, dout, din;
   logic [ADDR_W-1:0] addr;
   int errors = 0, cmp_count = 0, cyc = 0;
   dps_host uut (.clk(clk), .rst_b(rst_b), .clk_en(clk_en),
      .cmd_valid(cmd_valid), .cmd(cmd), .cmd_ready_q(rdy), .done_q(done_q),
      .owned_q(owned_q), .rdata_q(rdata_q), .semaphore_select_n_q(sel_n),
      .ce_n_q(), .rw_n_q(rw_n), .oe_n_q(oe_n), .addr_q(addr),
      .dout_q(dout), .dout_en_q(den), .din(din));
   dps_sem_model u_mod (.sel_n(sel_n), .rw_n(rw_n), .oe_n(oe_n),
      .addr(addr), .dout(dout), .din(din), .oth_we(oth_we),
      .oth_val(oth_val), .oth_idx(oth_idx));
   always #2.5 clk = ~clk;
   always @(posedge clk) begin
      cyc++;
      if (cyc > 4000) begin
         errors++;
         tally_and_finish();
      end
   end
   task automatic check(string nm, logic [DATA_W-1:0] s, e);
      cmp_count++;
      if (s !== e) begin
         errors++;
         $display("Error %s expected %h seen %h", nm, e, s);
      end
   endtask : check
   task automatic issue(dps_op_t op, logic [IDX_W-1:0] i);
      for (int n = 0; n < 80 && rdy !== 1'b1; n++) @(negedge clk);
      cmd = '{op: op, index: i};
      cmd_valid = 1'b1;
      for (int n = 0; n < 40 && sel_n !== 1'b0; n++) @(negedge clk);
      cmd_valid = 1'b0;
   endtask : issue
   task automatic run(dps_op_t op, logic [IDX_W-1:0] i);
      issue(op, i);
      for (int n = 0; n < 40 && done_q !== 1'b1 &&
         (op != DPS_OP_RELEASE || rdy !== 1'b1); n++) @(negedge clk);
   endtask : run
   task automatic other(logic [IDX_W-1:0] i, logic v);
      oth_idx = i;
      oth_val = v;
      oth_we = 1'b1;
      @(negedge clk);
      oth_we = 1'b0;
   endtask : other
   task automatic tally_and_finish();
      $display("checks %0d mismatches %0d", cmp_count, errors);
      if (errors == 0 && cmp_count > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask : tally_and_finish
   initial begin
      repeat (8) @(negedge clk);
      check("idle pins", {sel_n, rw_n, oe_n, den}, 4'hE);
      rst_b = 1'b1;
      $display("reset test done");
      for (int i = 0; i < SEM_COUNT; i++) begin
         run(DPS_OP_RELEASE, i);
         other(i, 1'b1);
      end
      foreach (ROWS[r]) begin
         if (ROWS[r].oth != 0) other(ROWS[r].idx, ROWS[r].oth == 2);
         run(ROWS[r].op, ROWS[r].idx);
         if (ROWS[r].op != DPS_OP_RELEASE) begin
            check("owned", owned_q, ROWS[r].own);
            check("rdata", rdata_q, {DATA_W{!ROWS[r].own}});
         end
      end
      $display("row test done");
      for (int i = 0; i < SEM_COUNT; i++) begin
         run(DPS_OP_ACQUIRE, i);
         check("sweep", owned_q, 1'b1);
      end
      $display("sweep test done");
      issue(DPS_OP_POLL, 3'h6);
      clk_en = 1'b0;
      pins = {sel_n, rw_n, oe_n, den};
      repeat (3) @(negedge clk);
      check("frozen pins", {sel_n, rw_n, oe_n, den}, pins);
      check("frozen done", done_q, 1'b0);
      clk_en = 1'b1;
      for (int n = 0; n < 40 && done_q !== 1'b1; n++) @(negedge clk);
      check("thawed owned", owned_q, 1'b1);
      check("thawed rdata", rdata_q, 9'h000);
      $display("clock enable test done");
      issue(DPS_OP_ACQUIRE, 3'h0);
      rst_b = 1'b0;
      @(negedge clk);
      check("reset pins", {sel_n, rw_n, oe_n, den}, 4'hE);
      check("reset owned", owned_q, 1'b0);
      rst_b = 1'b1;
      repeat (2) @(negedge clk);
      check("sweep holds cmds", rdy, 1'b0);
      run(DPS_OP_POLL, 3'h5);
      check("swept owned", owned_q, 1'b0);
      check("swept rdata", rdata_q, {DATA_W{1'b1}});
      $display("midrun reset test done");
      tally_and_finish();
   end
endmodule : dps_host_tb
